//--- verilog/olmpc_pkg.sv
// Register map, field layout and constants of the one-line-mode port configuration block
package olmpc_pkg;
   // Register indices and byte addresses
   localparam int OLMPC_IDX_FUNC = 3;
   localparam int OLMPC_IDX_IFMT = 4;
   localparam int OLMPC_IDX_MISC = 5;
   localparam int OLMPC_IDX_CTRL = 6;
   localparam int OLMPC_IDX_STAT = 7;
   localparam logic [7:0] OLMPC_ADDR_FUNC = 8'(OLMPC_IDX_FUNC * 4);
   localparam logic [7:0] OLMPC_ADDR_IFMT = 8'(OLMPC_IDX_IFMT * 4);
   localparam logic [7:0] OLMPC_ADDR_MISC = 8'(OLMPC_IDX_MISC * 4);
   localparam logic [7:0] OLMPC_ADDR_CTRL = 8'(OLMPC_IDX_CTRL * 4);
   localparam logic [7:0] OLMPC_ADDR_STAT = 8'(OLMPC_IDX_STAT * 4);
   // Functional mode fields
   localparam int OLMPC_POS_DAC_SPEED = 0;
   localparam int OLMPC_POS_ADC_SPEED = 2;
   localparam int OLMPC_POS_ADC_CLK_SEL = 4;
   // Interface format fields
   localparam int OLMPC_POS_SERIAL_FORMAT = 0;
   localparam int OLMPC_POS_ADC_OL = 4;
   localparam int OLMPC_POS_DAC_OL = 6;
   // Misc control fields
   localparam int OLMPC_POS_DAC_MASTER = 0;
   localparam int OLMPC_POS_ADC_MASTER = 1;
   localparam int OLMPC_POS_EXT_SRC = 2;
   // Control fields
   localparam int OLMPC_POS_CFG_SEL = 0;
   localparam int OLMPC_POS_PORT_EN = 1;
   // Status fields
   localparam int OLMPC_POS_VALID = 0;
   localparam int OLMPC_POS_DAC_SEEN = 1;
   localparam int OLMPC_POS_ADC_SEEN = 2;
   // Speed, one-line and config select codes
   localparam logic [1:0] OLMPC_SINGLE_SPEED = 2'h0;
   localparam logic [1:0] OLMPC_DOUBLE_SPEED = 2'h1;
   localparam logic [1:0] OLMPC_QUAD_SPEED = 2'h2;
   localparam logic [1:0] OLMPC_OL_NONE = 2'h0;
   localparam logic [1:0] OLMPC_OL_ONE = 2'h1;
   localparam logic [1:0] OLMPC_OL_TWO = 2'h2;
   localparam logic OLMPC_CFG_THREE = 1'h0;
   localparam logic OLMPC_CFG_FOUR = 1'h1;
   // Reset values
   localparam logic [1:0] OLMPC_RST_SPEED = 2'h0;
   localparam logic [2:0] OLMPC_RST_FORMAT = 3'h0;
   localparam logic [1:0] OLMPC_RST_OL = 2'h0;
   localparam logic OLMPC_RST_BIT = 1'h0;
   // Capacity figures and synchroniser width
   localparam logic [2:0] OLMPC_SIX_CH = 3'h6;
   localparam logic [2:0] OLMPC_TWO_CH = 3'h2;
   localparam logic [4:0] OLMPC_ADC_BITS_CFG3 = 5'h14;
   localparam logic [4:0] OLMPC_BITS_FULL = 5'h18;
   localparam logic [1:0] OLMPC_INPUTS_ONE_LINE = 2'h1;
   localparam logic [1:0] OLMPC_INPUTS_CFG4 = 2'h2;
   localparam logic [1:0] OLMPC_INPUTS_PLAIN = 2'h3;
   localparam int OLMPC_SYNC_WIDTH = 2;
endpackage : olmpc_pkg

//--- verilog/olmpc_sync.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module olmpc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end
   assign q_o = sync_r;
endmodule : olmpc_sync
`default_nettype wire

//--- verilog/olmpc_top.sv
// One-line-mode serial port configuration registers, validity check and clock routing
// Behaviour
// - Config three: six DAC, six ADC channels, ADC 20-bit, DAC 24-bit, 48 kHz.
// - Config three: ADC data output clocked by ADC port; port rates may differ.
// - Config three: each speed field takes single, double or quad; frame clocks independent.
// - Serial format applies only while neither port is in one-line mode.
// - Config four: six DAC channels on two inputs, two ADC channels, 24-bit.
// - Config four: clock select picks DAC port or ADC port clocks for ADC output.
// - Config four: DAC and ADC ports may run at different sample rates.
// - External source bit one means DAC port clocks, zero ADC port clocks.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module olmpc_top
   import olmpc_pkg::*;
(
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic DAC_FRAME_CLOCK_I,
   input wire logic ADC_FRAME_CLOCK_I,
   output logic ADC_OUT_CLK_FROM_ADC_O,
   output logic EXT_ADC_CLK_FROM_DAC_O,
   output logic DAC_PORT_MASTER_O,
   output logic ADC_PORT_MASTER_O,
   output logic [1:0] DAC_SPEED_O,
   output logic [1:0] ADC_SPEED_O,
   output logic [1:0] DAC_ONE_LINE_O,
   output logic [1:0] ADC_ONE_LINE_O,
   output logic [2:0] SERIAL_FORMAT_O,
   output logic SERIAL_FORMAT_EN_O,
   output logic CONFIG_FAULT_O,
   output logic PORTS_ENABLE_O,
   output logic [2:0] DAC_CHANNELS_O,
   output logic [2:0] ADC_CHANNELS_O,
   output logic [4:0] DAC_SAMPLE_BITS_O,
   output logic [4:0] ADC_SAMPLE_BITS_O,
   output logic [1:0] DAC_DATA_INPUTS_O
);
   typedef struct packed {
      logic [31:0] prdata;
      logic [1:0] dac_speed_field;
      logic [1:0] adc_speed_field;
      logic adc_clk_sel;
      logic [2:0] serial_format_field;
      logic [1:0] adc_one_line_field;
      logic [1:0] dac_one_line_field;
      logic dac_port_master_select;
      logic adc_port_master_select;
      logic external_adc_clock_source;
      logic cfg_sel;
      logic port_en;
      logic valid;
      logic fmt_en;
      logic dac_seen;
      logic adc_seen;
      logic [1:0] frame_prev;
      logic [2:0] dac_ch;
      logic [2:0] adc_ch;
      logic [4:0] dac_bits;
      logic [4:0] adc_bits;
      logic [1:0] dac_inputs;
   } olmpc_state_type;

   olmpc_state_type st_r;
   olmpc_state_type st_nxt;
   logic [1:0] frame_sync;
   logic mapped;
   logic wr_en;
   logic [1:0] frame_edge;
   logic speed_ok;
   logic dac_ol_ok;
   logic cfg3_ok;
   logic cfg4_ok;
   logic cfg_ok;

   olmpc_sync #(.WIDTH(OLMPC_SYNC_WIDTH)) u_frame_sync (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .d_i({ADC_FRAME_CLOCK_I, DAC_FRAME_CLOCK_I}),
      .q_o(frame_sync)
   );

   assign mapped = (PADDR_I == OLMPC_ADDR_FUNC) || (PADDR_I == OLMPC_ADDR_IFMT) || (PADDR_I == OLMPC_ADDR_MISC) ||
                   (PADDR_I == OLMPC_ADDR_CTRL) || (PADDR_I == OLMPC_ADDR_STAT);
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && mapped;
   assign frame_edge = frame_sync ^ st_r.frame_prev;

   assign speed_ok = (st_r.dac_speed_field != 2'h3) && (st_r.adc_speed_field != 2'h3);
   assign dac_ol_ok = (st_r.dac_one_line_field == OLMPC_OL_NONE) ||
                      ((st_r.dac_one_line_field == OLMPC_OL_ONE) && (st_r.dac_speed_field != OLMPC_QUAD_SPEED)) ||
                      ((st_r.dac_one_line_field == OLMPC_OL_TWO) && (st_r.dac_speed_field == OLMPC_SINGLE_SPEED));
   assign cfg3_ok = st_r.adc_clk_sel && st_r.dac_port_master_select && !st_r.external_adc_clock_source &&
                    ((st_r.adc_one_line_field == OLMPC_OL_NONE) ||
                     ((st_r.adc_one_line_field == OLMPC_OL_ONE) && (st_r.adc_speed_field == OLMPC_SINGLE_SPEED)));
   assign cfg4_ok = (st_r.adc_one_line_field == OLMPC_OL_NONE) && !st_r.external_adc_clock_source;
   assign cfg_ok = speed_ok && dac_ol_ok && ((st_r.cfg_sel == OLMPC_CFG_FOUR) ? cfg4_ok : cfg3_ok);

   always_comb begin
      st_nxt = st_r;
      st_nxt.frame_prev = frame_sync;
      st_nxt.valid = cfg_ok;
      st_nxt.fmt_en = (st_r.dac_one_line_field == OLMPC_OL_NONE) && (st_r.adc_one_line_field == OLMPC_OL_NONE);
      if (st_r.cfg_sel == OLMPC_CFG_FOUR) begin
         st_nxt.dac_ch = OLMPC_SIX_CH;
         st_nxt.adc_ch = OLMPC_TWO_CH;
         st_nxt.dac_bits = OLMPC_BITS_FULL;
         st_nxt.adc_bits = OLMPC_BITS_FULL;
         st_nxt.dac_inputs = OLMPC_INPUTS_CFG4;
      end else begin
         st_nxt.dac_ch = OLMPC_SIX_CH;
         st_nxt.adc_ch = OLMPC_SIX_CH;
         st_nxt.dac_bits = OLMPC_BITS_FULL;
         st_nxt.adc_bits = OLMPC_ADC_BITS_CFG3;
         st_nxt.dac_inputs = (st_r.dac_one_line_field == OLMPC_OL_NONE) ? OLMPC_INPUTS_PLAIN : OLMPC_INPUTS_ONE_LINE;
      end
      // Read data captured in the setup phase
      if (PSEL_I && !PENABLE_I) begin
         st_nxt.prdata = '0;
         case (PADDR_I)
            OLMPC_ADDR_FUNC: begin
               st_nxt.prdata[OLMPC_POS_DAC_SPEED +: 2] = st_r.dac_speed_field;
               st_nxt.prdata[OLMPC_POS_ADC_SPEED +: 2] = st_r.adc_speed_field;
               st_nxt.prdata[OLMPC_POS_ADC_CLK_SEL] = st_r.adc_clk_sel;
            end
            OLMPC_ADDR_IFMT: begin
               st_nxt.prdata[OLMPC_POS_SERIAL_FORMAT +: 3] = st_r.serial_format_field;
               st_nxt.prdata[OLMPC_POS_ADC_OL +: 2] = st_r.adc_one_line_field;
               st_nxt.prdata[OLMPC_POS_DAC_OL +: 2] = st_r.dac_one_line_field;
            end
            OLMPC_ADDR_MISC: begin
               st_nxt.prdata[OLMPC_POS_DAC_MASTER] = st_r.dac_port_master_select;
               st_nxt.prdata[OLMPC_POS_ADC_MASTER] = st_r.adc_port_master_select;
               st_nxt.prdata[OLMPC_POS_EXT_SRC] = st_r.external_adc_clock_source;
            end
            OLMPC_ADDR_CTRL: begin
               st_nxt.prdata[OLMPC_POS_CFG_SEL] = st_r.cfg_sel;
               st_nxt.prdata[OLMPC_POS_PORT_EN] = st_r.port_en;
            end
            OLMPC_ADDR_STAT: begin
               st_nxt.prdata[OLMPC_POS_VALID] = st_r.valid;
               st_nxt.prdata[OLMPC_POS_DAC_SEEN] = st_r.dac_seen;
               st_nxt.prdata[OLMPC_POS_ADC_SEEN] = st_r.adc_seen;
            end
            default: begin
               st_nxt.prdata = '0;
            end
         endcase
      end
      if (wr_en) begin
         case (PADDR_I)
            OLMPC_ADDR_FUNC: begin
               st_nxt.dac_speed_field = PWDATA_I[OLMPC_POS_DAC_SPEED +: 2];
               st_nxt.adc_speed_field = PWDATA_I[OLMPC_POS_ADC_SPEED +: 2];
               st_nxt.adc_clk_sel = PWDATA_I[OLMPC_POS_ADC_CLK_SEL];
            end
            OLMPC_ADDR_IFMT: begin
               st_nxt.serial_format_field = PWDATA_I[OLMPC_POS_SERIAL_FORMAT +: 3];
               st_nxt.adc_one_line_field = PWDATA_I[OLMPC_POS_ADC_OL +: 2];
               st_nxt.dac_one_line_field = PWDATA_I[OLMPC_POS_DAC_OL +: 2];
            end
            OLMPC_ADDR_MISC: begin
               st_nxt.dac_port_master_select = PWDATA_I[OLMPC_POS_DAC_MASTER];
               st_nxt.adc_port_master_select = PWDATA_I[OLMPC_POS_ADC_MASTER];
               st_nxt.external_adc_clock_source = PWDATA_I[OLMPC_POS_EXT_SRC];
            end
            OLMPC_ADDR_CTRL: begin
               st_nxt.cfg_sel = PWDATA_I[OLMPC_POS_CFG_SEL];
               st_nxt.port_en = PWDATA_I[OLMPC_POS_PORT_EN];
            end
            default: begin
               st_nxt.cfg_sel = st_r.cfg_sel;
            end
         endcase
      end
      // independent frame activity, set wins over clear
      st_nxt.dac_seen = (st_r.dac_seen && !(wr_en && (PADDR_I == OLMPC_ADDR_STAT) && PWDATA_I[OLMPC_POS_DAC_SEEN]))
                        || frame_edge[0];
      st_nxt.adc_seen = (st_r.adc_seen && !(wr_en && (PADDR_I == OLMPC_ADDR_STAT) && PWDATA_I[OLMPC_POS_ADC_SEEN]))
                        || frame_edge[1];
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         st_r <= '0;
         st_r.dac_speed_field <= OLMPC_RST_SPEED;
         st_r.adc_speed_field <= OLMPC_RST_SPEED;
         st_r.serial_format_field <= OLMPC_RST_FORMAT;
         st_r.adc_one_line_field <= OLMPC_RST_OL;
         st_r.dac_one_line_field <= OLMPC_RST_OL;
         st_r.external_adc_clock_source <= OLMPC_RST_BIT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign PRDATA_O = st_r.prdata;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;
   assign ADC_OUT_CLK_FROM_ADC_O = st_r.adc_clk_sel;
   assign EXT_ADC_CLK_FROM_DAC_O = st_r.external_adc_clock_source;
   assign DAC_PORT_MASTER_O = st_r.dac_port_master_select;
   assign ADC_PORT_MASTER_O = st_r.adc_port_master_select;
   assign DAC_SPEED_O = st_r.dac_speed_field;
   assign ADC_SPEED_O = st_r.adc_speed_field;
   assign DAC_ONE_LINE_O = st_r.dac_one_line_field;
   assign ADC_ONE_LINE_O = st_r.adc_one_line_field;
   assign SERIAL_FORMAT_O = st_r.serial_format_field;
   assign SERIAL_FORMAT_EN_O = st_r.fmt_en;
   assign CONFIG_FAULT_O = !st_r.valid;
   assign PORTS_ENABLE_O = st_r.port_en && st_r.valid;
   assign DAC_CHANNELS_O = st_r.dac_ch;
   assign ADC_CHANNELS_O = st_r.adc_ch;
   assign DAC_SAMPLE_BITS_O = st_r.dac_bits;
   assign ADC_SAMPLE_BITS_O = st_r.adc_bits;
   assign DAC_DATA_INPUTS_O = st_r.dac_inputs;

   unmapped_err_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (PSEL_I && PENABLE_I && !mapped) |-> (PSLVERR_O && PREADY_O))
      else $error("unmapped access not flagged");
   write_effect_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (wr_en && (PADDR_I == OLMPC_ADDR_FUNC)) |=> (DAC_SPEED_O == $past(PWDATA_I[OLMPC_POS_DAC_SPEED +: 2])))
      else $error("speed write lost");
   format_gate_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      RST_N_I |=> (SERIAL_FORMAT_EN_O ==
                   ($past(DAC_ONE_LINE_O) == OLMPC_OL_NONE && $past(ADC_ONE_LINE_O) == OLMPC_OL_NONE)))
      else $error("format gate wrong");
   cfg3_adc_two_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r.cfg_sel == OLMPC_CFG_THREE && ADC_ONE_LINE_O == OLMPC_OL_TWO) [*2] |-> CONFIG_FAULT_O && !PORTS_ENABLE_O)
      else $error("adc mode two accepted in config three");
   cfg3_master_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r.cfg_sel == OLMPC_CFG_THREE && !DAC_PORT_MASTER_O) [*2] |-> CONFIG_FAULT_O)
      else $error("slave dac port accepted in config three");
   cfg4_adc_ol_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (st_r.cfg_sel == OLMPC_CFG_FOUR && ADC_ONE_LINE_O != OLMPC_OL_NONE) [*2] |-> CONFIG_FAULT_O)
      else $error("adc one-line accepted in config four");
   cfg4_capacity_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ($past(RST_N_I) && $past(st_r.cfg_sel) == OLMPC_CFG_FOUR) |->
      (ADC_CHANNELS_O == OLMPC_TWO_CH && DAC_DATA_INPUTS_O == OLMPC_INPUTS_CFG4))
      else $error("config four capacity wrong");
   cfg3_capacity_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      ($past(RST_N_I) && $past(st_r.cfg_sel) == OLMPC_CFG_THREE) |->
      (ADC_SAMPLE_BITS_O == OLMPC_ADC_BITS_CFG3 && ADC_CHANNELS_O == OLMPC_SIX_CH))
      else $error("config three capacity wrong");
   seen_set_wins_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      frame_edge[0] |=> st_r.dac_seen)
      else $error("dac frame activity lost");
   ext_clear_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
      (EXT_ADC_CLK_FROM_DAC_O && $stable(EXT_ADC_CLK_FROM_DAC_O)) |-> CONFIG_FAULT_O || !$past(st_r.valid))
      else $error("external source one accepted");
endmodule : olmpc_top
`default_nettype wire

//--- verification/olmpc_host_model.sv
// Audio host model that drives the two serial port frame clocks
`timescale 1ns/1ps
`default_nettype none
module olmpc_host_model #(
   parameter int DAC_HALF_NS = 40,
   parameter int ADC_HALF_NS = 65
) (
   input wire logic run_i,
   output logic dac_frame_clock_o,
   output logic adc_frame_clock_o
);
   always begin
      if (run_i === 1'b1) begin
         #(DAC_HALF_NS) dac_frame_clock_o = ~dac_frame_clock_o;
      end else begin
         dac_frame_clock_o = 1'b0;
         @(posedge run_i);
      end
   end
   always begin
      if (run_i === 1'b1) begin
         #(ADC_HALF_NS) adc_frame_clock_o = ~adc_frame_clock_o;
      end else begin
         adc_frame_clock_o = 1'b0;
         @(posedge run_i);
      end
   end
endmodule : olmpc_host_model
`default_nettype wire

//--- verification/olmpc_top_tb.sv
// Self-checking testbench of the one-line-mode port configuration block
`timescale 1ns/1ps
`default_nettype none
module olmpc_top_tb;
   import olmpc_pkg::*;
   logic clk, rst_n, psel, penable, pwrite, run, dfc, afc;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, out_adc, ext_dac, dm_o, am_o, fen, fault, pen_o;
   logic [1:0] dsp_o, asp_o, dol_o, aol_o, inp_o;
   logic [2:0] fmt_o, dch_o, ach_o;
   logic [4:0] dbits_o, abits_o;
   int dsp, asp, csel, fmt, aol, dol, dm, am, ext, cfg, pen;
   int fails, checks, cycles, seed;
   logic [31:0] r;
   logic e;

   olmpc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
      .DAC_FRAME_CLOCK_I(dfc), .ADC_FRAME_CLOCK_I(afc), .ADC_OUT_CLK_FROM_ADC_O(out_adc),
      .EXT_ADC_CLK_FROM_DAC_O(ext_dac), .DAC_PORT_MASTER_O(dm_o), .ADC_PORT_MASTER_O(am_o),
      .DAC_SPEED_O(dsp_o), .ADC_SPEED_O(asp_o), .DAC_ONE_LINE_O(dol_o), .ADC_ONE_LINE_O(aol_o),
      .SERIAL_FORMAT_O(fmt_o), .SERIAL_FORMAT_EN_O(fen), .CONFIG_FAULT_O(fault), .PORTS_ENABLE_O(pen_o),
      .DAC_CHANNELS_O(dch_o), .ADC_CHANNELS_O(ach_o), .DAC_SAMPLE_BITS_O(dbits_o),
      .ADC_SAMPLE_BITS_O(abits_o), .DAC_DATA_INPUTS_O(inp_o));
   olmpc_host_model host (.run_i(run), .dac_frame_clock_o(dfc), .adc_frame_clock_o(afc));

   always #2.5 clk = ~clk;

   function automatic int rnd(input int n);
      return ($random(seed) & 32'h7fffffff) % n;
   endfunction : rnd

   function automatic logic model_valid();
      logic v;
      v = (dsp != 3) && (asp != 3) && (dol != 3) && (aol != 3) && (ext == 0);
      if (dol == 1 && dsp == 2) v = 1'b0;
      if (dol == 2 && dsp != 0) v = 1'b0;
      if (cfg == 0) v = v && csel == 1 && dm == 1 && (aol == 0 || (aol == 1 && asp == 0));
      else v = v && aol == 0;
      return v;
   endfunction : model_valid

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
      chk(32'(e), 32'h0);
   endtask : rd_chk

   task automatic program_cfg();
      apb(1'b1, OLMPC_ADDR_FUNC, 32'(dsp | (asp << 2) | (csel << 4)));
      apb(1'b1, OLMPC_ADDR_IFMT, 32'(fmt | (aol << 4) | (dol << 6)));
      apb(1'b1, OLMPC_ADDR_MISC, 32'(dm | (am << 1) | (ext << 2)));
      apb(1'b1, OLMPC_ADDR_CTRL, 32'(cfg | (pen << 1)));
   endtask : program_cfg

   task automatic check_all(input int seen_bits);
      logic v;
      v = model_valid();
      repeat (3) @(posedge clk);
      chk(32'(fault), 32'(!v));
      chk(32'(pen_o), 32'(pen == 1 && v));
      chk(32'(dsp_o), 32'(dsp));
      chk(32'(asp_o), 32'(asp));
      chk(32'(out_adc), 32'(csel));
      chk(32'(ext_dac), 32'(ext));
      chk(32'(dm_o), 32'(dm));
      chk(32'(am_o), 32'(am));
      chk(32'(dol_o), 32'(dol));
      chk(32'(aol_o), 32'(aol));
      chk(32'(fmt_o), 32'(fmt));
      chk(32'(fen), 32'(dol == 0 && aol == 0));
      chk(32'(dch_o), 32'(OLMPC_SIX_CH));
      chk(32'(ach_o), 32'(cfg ? OLMPC_TWO_CH : OLMPC_SIX_CH));
      chk(32'(dbits_o), 32'(OLMPC_BITS_FULL));
      chk(32'(abits_o), 32'(cfg ? OLMPC_BITS_FULL : OLMPC_ADC_BITS_CFG3));
      chk(32'(inp_o), 32'(cfg ? OLMPC_INPUTS_CFG4 : (dol == 0 ? OLMPC_INPUTS_PLAIN : OLMPC_INPUTS_ONE_LINE)));
      rd_chk(OLMPC_ADDR_FUNC, 32'(dsp | (asp << 2) | (csel << 4)));
      rd_chk(OLMPC_ADDR_IFMT, 32'(fmt | (aol << 4) | (dol << 6)));
      rd_chk(OLMPC_ADDR_MISC, 32'(dm | (am << 1) | (ext << 2)));
      rd_chk(OLMPC_ADDR_CTRL, 32'(cfg | (pen << 1)));
      rd_chk(OLMPC_ADDR_STAT, 32'(v | seen_bits));
   endtask : check_all

   task automatic end_sim();
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         end_sim();
      end
   end

   initial begin
      clk = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; run = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; fails = 0; checks = 0; cycles = 0; seed = 26846;
      {dsp, asp, csel, fmt, aol, dol, dm, am, ext, cfg, pen} = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      check_all(0);
      apb(1'b1, 8'h20, 32'hffffffff);
      chk(32'(e), 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(r, 32'h0);
      chk(32'(e), 32'h1);
      check_all(0);
      for (int s = 0; s < 3; s++) begin
         dsp = s;
         asp = s;
         csel = 1;
         dm = 1;
         ext = 0;
         aol = 0;
         dol = 0;
         cfg = 0;
         pen = 1;
         program_cfg();
         check_all(0);
      end
      for (int i = 0; i < 40; i++) begin
         fmt = rnd(8); pen = rnd(2); cfg = rnd(2); dsp = rnd(3); asp = rnd(3); dol = rnd(3); am = rnd(2);
         if (dol == 1 && dsp == 2) dsp = 0;
         if (dol == 2) dsp = 0;
         ext = 0;
         if (cfg == 0) begin
            csel = 1; dm = 1; aol = rnd(2);
            if (aol == 1) asp = 0;
         end else begin
            csel = rnd(2); dm = rnd(2); aol = 0;
         end
         if (i % 2 == 1) begin
            dsp = rnd(4); asp = rnd(4); aol = rnd(3); ext = rnd(2); dm = rnd(2); csel = rnd(2);
         end
         program_cfg();
         check_all(0);
      end
      run <= 1'b1;
      repeat (100) @(posedge clk);
      check_all(6);
      run <= 1'b0;
      // Let the slower frame clock finish its last half period before clearing
      repeat (40) @(posedge clk);
      apb(1'b1, OLMPC_ADDR_STAT, 32'h6);
      check_all(0);
      end_sim();
   end
endmodule : olmpc_top_tb
`default_nettype wire
